// ### rtl/wbdb_bridge.sv
// Word-to-byte DMA bridge: sequencer, strobes, data and address paths
`timescale 1ns/10ps
module wbdb_bridge (
  input wire logic clk,
  input wire logic reset,
  input wire logic clkEn,
  input wire logic transmitClock,
  input wire logic dmaDataStrobe,
  input wire logic ctrlReadDir,
  input wire logic byteMode,
  input wire logic addrLatchStrobe,
  input wire logic ctrlReady,
  input wire logic busGrantAck,
  input wire logic cpuRd,
  input wire logic cpuWr,
  input wire logic portCycleRequest,
  input wire logic opcodeFetchCycle,
  input wire logic intReq,
  input wire logic nmiReq,
  input wire logic holdReq,
  input wire logic [wbdb_pkg::CPU_ADDR_W-1:0] cpuAddr,
  input wire logic [3:0] ctrlAddrHigh,
  input wire logic [15:0] sharedAddressDataIn,
  output logic [15:0] sharedAddressDataOut,
  output logic [1:0] sharedAddressDataOe,
  input wire logic [7:0] cpuDataIn,
  output logic [7:0] cpuDataOut,
  output logic cpuDataOe,
  input wire logic [7:0] memDataIn,
  output logic [7:0] memDataOut,
  output logic memDataOe,
  output logic holdGrant,
  output logic stateBitZero,
  output logic [3:0] upperStateBits,
  output logic memoryRequestStrobe,
  output logic memRead,
  output logic memStore,
  output logic lowAddressSelect,
  output logic dmaReady,
  output logic ioDataStrobe,
  output logic ioCtrlRead,
  output logic cpuWait,
  output logic [15:1] dmaAddr,
  output logic [3:0] dmaAddrHigh,
  output logic [7:0] bankAddr,
  output logic bankAddrOe,
  output logic intSync,
  output logic nmiSync,
  output logic busRequestSync
);
  import wbdb_pkg::*;

  typedef struct packed {
    logic tclkPrev;
    logic dasPrev;
    logic sq0;
    logic [3:0] upper;
    logic holdGrant;
    logic memory_request_strobe;
    logic memRead;
    logic memStore;
    logic lowSel;
    logic dmaReady;
    logic ioStrobe;
    logic ioRead;
    logic cpuWait;
    logic [7:0] bankReg;
    logic bankOe;
    logic [7:0] staging;
    logic [7:0] rdLow;
    logic [7:0] wrLow;
    logic [15:1] addr;
    logic addrA00;
    logic [3:0] addrHigh;
    logic [15:0] dalOut;
    logic [1:0] dalOe;
    logic [7:0] cpuOut;
    logic cpuOe;
    logic [7:0] memOut;
    logic memOe;
    logic intS;
    logic nmiS;
    logic busReqS;
  } wbdb_main_s;

  wbdb_main_s q;
  wbdb_main_s d;
  logic [SYNC_W-1:0] pinRaw;
  logic [SYNC_W-1:0] sy;
  logic [3:0] grayNext;
  logic tick;
  logic dma_data_strobe;
  logic run;
  logic pre;
  logic csAny;
  logic csCtrl;
  logic csLow;
  logic csBank;
  logic [2:0] sel;

  always_comb begin
    pinRaw = '0;
    pinRaw[SI_TRANSMIT_CLOCK] = transmitClock;
    pinRaw[SI_DAS] = dmaDataStrobe;
    pinRaw[SI_RDIR] = ctrlReadDir;
    pinRaw[SI_BYTE] = byteMode;
    pinRaw[SI_ALE] = addrLatchStrobe;
    pinRaw[SI_RDY] = ctrlReady;
    pinRaw[SI_ACK] = busGrantAck;
    pinRaw[SI_RD] = cpuRd;
    pinRaw[SI_WR] = cpuWr;
    pinRaw[SI_PORT] = portCycleRequest;
    pinRaw[SI_FETCH] = opcodeFetchCycle;
    pinRaw[SI_INT] = intReq;
    pinRaw[SI_NMI] = nmiReq;
    pinRaw[SI_HOLD] = holdReq;
  end

  wbdb_sync #(
    .W(SYNC_W)
  ) pinSync (
    .clk(clk),
    .reset(reset),
    .clkEn(clkEn),
    .pinIn(pinRaw),
    .syncOut(sy)
  );

  wbdb_gray_next grayStep (
    .cur(q.upper),
    .nxt(grayNext)
  );

  always_comb begin
    d = q;
    dma_data_strobe = sy[SI_DAS];
    tick = sy[SI_TRANSMIT_CLOCK] & ~q.tclkPrev;
    run = q.holdGrant & dma_data_strobe;
    sel = cpuAddr[CA_SEL_HI:CA_SEL_LO];
    // Port decode is only live while the processor owns the bus
    csAny = sy[SI_PORT] & ~sy[SI_FETCH] & ~q.holdGrant;
    csCtrl = csAny & (sel == SEL_CTRL) & cpuAddr[CA_A00];
    csLow = csAny & (sel == SEL_CTRL) & ~cpuAddr[CA_A00];
    csBank = csAny & (sel == SEL_BANK);
    pre = q.upper[SQ2] & q.upper[SQ3] & ~q.upper[SQ4];
    d.tclkPrev = sy[SI_TRANSMIT_CLOCK];
    d.dasPrev = dma_data_strobe;
    d.holdGrant = sy[SI_ACK];
    d.bankOe = ~sy[SI_ACK];
    d.intS = sy[SI_INT];
    d.nmiS = sy[SI_NMI];
    d.busReqS = sy[SI_HOLD];

    // Sequencer
    if (!run) begin
      d.sq0 = 1'b0;
      d.upper = ST_IDLE;
    end else if (tick) begin
      // One upper state per transmit clock keeps the precharge gap at 200ns
      d.sq0 = ~q.sq0;
      d.upper = grayNext;
    end

    // Strobe shaping from the upper state bits
    if (q.holdGrant) begin
      d.ioStrobe = 1'b0;
      d.ioRead = 1'b0;
      d.cpuWait = 1'b0;
      if (sy[SI_BYTE]) begin
        d.dmaReady = dma_data_strobe & ~sy[SI_ALE];
        d.lowSel = q.addrA00;
        d.memStore = ~sy[SI_RDIR] & dma_data_strobe
          & (q.upper[SQ2] | q.upper[SQ3] | q.upper[SQ4]);
      end else begin
        d.dmaReady = dma_data_strobe & ((~q.upper[SQ1] & ~q.upper[SQ2] & q.upper[SQ3])
          | (~q.upper[SQ2] & q.upper[SQ3] & ~q.upper[SQ4])
          | q.upper[SQ4]);
        d.lowSel = q.upper[SQ3] | q.upper[SQ4];
        d.memStore = ~sy[SI_RDIR] & dma_data_strobe
          & ((q.upper[SQ2] & ~q.upper[SQ3] & ~q.upper[SQ4])
          | (~q.upper[SQ1] & ~q.upper[SQ2] & q.upper[SQ3])
          | (~q.upper[SQ2] & q.upper[SQ3] & q.upper[SQ4]));
      end
      // Precharge gap keeps request and read idle; strobe drop ends request, read, store and ready
      d.memory_request_strobe = dma_data_strobe & ~pre;
      d.memRead = sy[SI_RDIR] & dma_data_strobe & ~pre;
    end else begin
      d.dmaReady = 1'b0;
      d.lowSel = 1'b0;
      d.memory_request_strobe = 1'b0;
      d.memRead = 1'b0;
      d.memStore = 1'b0;
      d.ioStrobe = csCtrl & (sy[SI_RD] | sy[SI_WR]);
      d.ioRead = csCtrl & sy[SI_RD];
      d.cpuWait = csCtrl & ~sy[SI_RDY];
    end

    // Address capture from the shared lines
    if (q.holdGrant && sy[SI_ALE]) begin
      d.addr = sharedAddressDataIn[15:1];
      d.addrA00 = sharedAddressDataIn[0];
      d.addrHigh = ctrlAddrHigh;
    end

    // Data paths
    d.dalOut = '0;
    d.dalOe = 2'b00;
    d.cpuOut = BYTE_ZERO;
    d.cpuOe = 1'b0;
    d.memOut = BYTE_ZERO;
    d.memOe = 1'b0;
    if (q.holdGrant) begin
      if (dma_data_strobe && sy[SI_RDIR]) begin
        if (sy[SI_BYTE]) begin
          d.dalOut = {memDataIn, memDataIn};
          d.dalOe = q.addrA00 ? 2'b10 : 2'b01;
        end else begin
          if (!q.lowSel && q.memRead) begin
            d.rdLow = memDataIn;
          end
          d.dalOut = {memDataIn, q.rdLow};
          d.dalOe = 2'b11;
        end
      end else if (dma_data_strobe) begin
        // Low byte is caught as the strobe rises, before the bus turns
        if (!q.dasPrev) begin
          d.wrLow = sharedAddressDataIn[7:0];
        end
        d.memOe = 1'b1;
        if (sy[SI_BYTE]) begin
          d.memOut = q.addrA00 ? sharedAddressDataIn[15:8]
            : sharedAddressDataIn[7:0];
        end else if (q.lowSel) begin
          d.memOut = sharedAddressDataIn[15:8];
        end else begin
          d.memOut = q.dasPrev ? q.wrLow : sharedAddressDataIn[7:0];
        end
      end
    end else begin
      if (csLow && sy[SI_WR]) begin
        d.staging = cpuDataIn;
      end
      if (csCtrl && sy[SI_WR]) begin
        d.dalOut = {cpuDataIn, q.staging};
        d.dalOe = 2'b11;
      end
      if (csCtrl && sy[SI_RD]) begin
        d.staging = sharedAddressDataIn[7:0];
        d.cpuOut = sharedAddressDataIn[15:8];
        d.cpuOe = 1'b1;
      end
      if (csLow && sy[SI_RD]) begin
        d.cpuOut = q.staging;
        d.cpuOe = 1'b1;
      end
      if (csBank && sy[SI_WR]) begin
        d.bankReg = cpuDataIn;
      end
      if (csBank && sy[SI_RD]) begin
        d.cpuOut = q.bankReg;
        d.cpuOe = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      q <= '0;
      q.bankOe <= 1'b1;
    end else if (clkEn) begin
      q <= d;
    end
  end

  assign sharedAddressDataOut = q.dalOut;
  assign sharedAddressDataOe = q.dalOe;
  assign cpuDataOut = q.cpuOut;
  assign cpuDataOe = q.cpuOe;
  assign memDataOut = q.memOut;
  assign memDataOe = q.memOe;
  assign holdGrant = q.holdGrant;
  assign stateBitZero = q.sq0;
  assign upperStateBits = q.upper;
  assign memoryRequestStrobe = q.memory_request_strobe;
  assign memRead = q.memRead;
  assign memStore = q.memStore;
  assign lowAddressSelect = q.lowSel;
  assign dmaReady = q.dmaReady;
  assign ioDataStrobe = q.ioStrobe;
  assign ioCtrlRead = q.ioRead;
  assign cpuWait = q.cpuWait;
  assign dmaAddr = q.addr;
  assign dmaAddrHigh = q.addrHigh;
  assign bankAddr = q.bankReg;
  // Bank outputs float once the controller owns the bus
  assign bankAddrOe = q.bankOe;
  assign intSync = q.intS;
  assign nmiSync = q.nmiS;
  assign busRequestSync = q.busReqS;

  // Checks
  sequence ackRise;
    $rose(busGrantAck) ##1 busGrantAck [*3];
  endsequence

  sequence runStep;
    clkEn && run && tick;
  endsequence

  property holdFollowsAck;
    @(posedge clk) disable iff (reset)
      (clkEn throughout ackRise) ##1 clkEn |=> holdGrant;
  endproperty

  property stepToggles;
    @(posedge clk) disable iff (reset)
      runStep |=> (stateBitZero != $past(stateBitZero));
  endproperty

  hold_sync_a: assert property (holdFollowsAck)
    else $error("hold grant did not follow acknowledge");

  sq0_toggle_a: assert property (stepToggles)
    else $error("state bit zero did not toggle on a step");

  seq_zero_a: assert property (@(posedge clk) disable iff (reset)
    clkEn && !run |=> (upperStateBits == ST_IDLE && !stateBitZero))
    else $error("sequencer not held at zero");

  gray_one_a: assert property (@(posedge clk) disable iff (reset)
    clkEn && run |=> $countones(upperStateBits
      ^ $past(upperStateBits)) <= 1)
    else $error("more than one upper state bit changed");

  no_tick_a: assert property (@(posedge clk) disable iff (reset)
    clkEn && run && !tick |=> $stable(upperStateBits)
      && $stable(stateBitZero))
    else $error("sequencer moved without a transmit clock edge");

  precharge_a: assert property (@(posedge clk) disable iff (reset)
    clkEn && q.holdGrant && (q.upper == ST_PRE_A || q.upper == ST_PRE_B)
      |=> !memoryRequestStrobe && !memRead)
    else $error("strobe active in precharge state");

  second_start_a: assert property (@(posedge clk) disable iff (reset)
    clkEn && q.holdGrant && dma_data_strobe && !sy[SI_BYTE] && q.upper == ST_SECOND
      |=> memoryRequestStrobe && lowAddressSelect && dmaReady)
    else $error("second transfer did not start in state 5");

  das_drop_a: assert property (@(posedge clk) disable iff (reset)
    clkEn && q.holdGrant && !dma_data_strobe |=> !memoryRequestStrobe
      && !memRead && !memStore && !dmaReady)
    else $error("strobes remain after DMA strobe dropped");

  io_wait_a: assert property (@(posedge clk) disable iff (reset)
    clkEn && csCtrl && !sy[SI_RDY] |=> cpuWait)
    else $error("wait not raised while controller not ready");

  parity_track_a: assert property (@(posedge clk) disable iff (reset)
    stateBitZero == ^upperStateBits)
    else $error("state bit zero out of step with upper state bits");
endmodule : wbdb_bridge

// ### rtl/wbdb_pkg.sv
// Constants shared by the word-to-byte DMA bridge
// Operation
// - Sequencer steps on transmit clock only while DMA strobe active.
// - Upper state bits follow four-bit Gray order, one bit per step.
// - State bit zero toggles each step: 5MHz, 50% duty, drives upper.
// - Upper state bits 1 to 4 shape the memory strobes.
// - Bus grant acknowledge registered and given out as hold grant.
// - I/O cycles: controller strobe and direction from processor strobes.
// - I/O cycles: controller ready reclocked onto processor wait.
// - DMA: drive memory request, read, store, cycle length, low address.
// - Byte transfer unstretched; word transfer becomes two byte transfers.
// - First transfer starts with the DMA strobe; store in state 1 (the code first raises store in state 3).
// - After first byte, strobes drop and low address select goes high.
// - States 6 and 7 keep strobes idle for 200ns precharge (in byte mode only request and read; store and ready stay active).
// - Second transfer starts in state 5 and raises ready.
// - Strobe drop ends ready, memory request, read and store.
// - Word read latches low byte, presents both with high byte.
// - Word write drives latched low byte first, then high byte.
// - Byte transfers enable only the lane being moved.
// - Bank register clears on reset; floats during DMA.
// - Address latched from shared lines while latch strobe high.
// - Address bit 0 reaches the bus only through the controller.
// - Interrupt, NMI and bus request lines registered before use.
package wbdb_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int TRANSMIT_CLOCK_PERIOD_NS = 100;
  localparam int PRECHARGE_NS = 200;
  localparam int PRECHARGE_TICKS = PRECHARGE_NS / TRANSMIT_CLOCK_PERIOD_NS;
  localparam int CPU_ADDR_W = 9;
  localparam int SYNC_W = 14;
  // Positions in the synchronised pin vector
  localparam int SI_TRANSMIT_CLOCK = 0;
  localparam int SI_DAS = 1;
  localparam int SI_RDIR = 2;
  localparam int SI_BYTE = 3;
  localparam int SI_ALE = 4;
  localparam int SI_RDY = 5;
  localparam int SI_ACK = 6;
  localparam int SI_RD = 7;
  localparam int SI_WR = 8;
  localparam int SI_PORT = 9;
  localparam int SI_FETCH = 10;
  localparam int SI_INT = 11;
  localparam int SI_NMI = 12;
  localparam int SI_HOLD = 13;
  // Port decode on processor address
  localparam int CA_A00 = 0;
  localparam int CA_SEL_LO = 6;
  localparam int CA_SEL_HI = 8;
  localparam logic [2:0] SEL_CTRL = 3'h7;
  localparam logic [2:0] SEL_BANK = 3'h6;
  // Upper state bit positions and named states
  localparam int SQ1 = 0;
  localparam int SQ2 = 1;
  localparam int SQ3 = 2;
  localparam int SQ4 = 3;
  localparam logic [3:0] ST_IDLE = 4'h0;
  localparam logic [3:0] ST_STORE1 = 4'h1;
  localparam logic [3:0] ST_SECOND = 4'h5;
  localparam logic [3:0] ST_PRE_A = 4'h6;
  localparam logic [3:0] ST_PRE_B = 4'h7;
  localparam logic [7:0] BANK_RESET = 8'h00;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
endpackage : wbdb_pkg

// ### rtl/wbdb_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
module wbdb_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic clkEn,
  input wire logic [W-1:0] pinIn,
  output logic [W-1:0] syncOut
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] val;
  } wbdb_sync_s;

  wbdb_sync_s q;
  wbdb_sync_s d;

  // Only stage two feeds stage three; the filter reads stages two and three
  always_comb begin
    d = q;
    d.s1 = pinIn;
    d.s2 = q.s1;
    d.s3 = q.s2;
    for (int i = 0; i < W; i++) begin
      if (q.s2[i] == q.s3[i]) begin
        d.val[i] = q.s2[i];
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      q <= '0;
    end else if (clkEn) begin
      q <= d;
    end
  end

  assign syncOut = q.val;
endmodule : wbdb_sync

// ### rtl/wbdb_gray_next.sv
// Successor of a four-bit reflected Gray code value
`timescale 1ns/10ps
module wbdb_gray_next (
  input wire logic [3:0] cur,
  output logic [3:0] nxt
);
  logic [3:0] bin;
  logic [3:0] inc;

  always_comb begin
    bin[3] = cur[3];
    for (int i = 2; i >= 0; i--) begin
      bin[i] = bin[i+1] ^ cur[i];
    end
    inc = bin + 4'h1;
    nxt = inc ^ (inc >> 1);
  end
endmodule : wbdb_gray_next

// ### bench/wbdb_mem_model.sv
// Byte-wide memory on the processor side of the bridge
`timescale 1ns/10ps
module wbdb_mem_model (
  input wire logic clk,
  input wire logic memRead,
  input wire logic lowAddressSelect,
  input wire logic [7:0] loByte,
  input wire logic [7:0] hiByte,
  output logic [7:0] memData
);
  logic [7:0] lastQ = 8'h5A;
  // A released bus never shows a stale byte: it toggles every cycle
  always_comb begin
    if (memRead) begin
      memData = lowAddressSelect ? hiByte : loByte;
    end else begin
      memData = ~lastQ;
    end
  end
  always_ff @(posedge clk) begin
    lastQ <= memData;
  end
endmodule : wbdb_mem_model

// ### bench/wbdb_bridge_bench.sv
// Self-checking bench for the word-to-byte DMA bridge
`timescale 1ns/10ps
module wbdb_bridge_bench;
  import wbdb_pkg::*;
  logic clk, reset, clkEn, transmitClock, dmaDataStrobe, ctrlReadDir;
  logic byteMode, addrLatchStrobe, ctrlReady, busGrantAck, cpuRd, cpuWr;
  logic portCycleRequest, opcodeFetchCycle, intReq, nmiReq, holdReq;
  logic [8:0] cpuAddr;
  logic [3:0] ctrlAddrHigh, upperStateBits, dmaAddrHigh;
  logic [15:0] sharedAddressDataIn, sharedAddressDataOut;
  logic [1:0] sharedAddressDataOe;
  logic [7:0] cpuDataIn, cpuDataOut, memDataIn, memDataOut, bankAddr;
  logic [7:0] memLo, memHi, lo, hi, b;
  logic cpuDataOe, memDataOe, holdGrant, stateBitZero, memoryRequestStrobe;
  logic memRead, memStore, lowAddressSelect, dmaReady, ioDataStrobe;
  logic ioCtrlRead, cpuWait, bankAddrOe, intSync, nmiSync, busRequestSync;
  logic [15:1] dmaAddr;
  logic [15:0] w;
  int numErrors = 0;
  int samplesChecked = 0;
  int cycles = 0;
  logic [3:0] grayTab [16] = '{4'h0, 4'h1, 4'h3, 4'h2, 4'h6, 4'h7, 4'h5,
    4'h4, 4'hC, 4'hD, 4'hF, 4'hE, 4'hA, 4'hB, 4'h9, 4'h8};
  localparam logic [8:0] PORT_HI = {SEL_CTRL, 5'h00, 1'b1};
  localparam logic [8:0] PORT_STAGE = {SEL_CTRL, 6'h00};
  localparam logic [8:0] PORT_BANK = {SEL_BANK, 6'h00};

  wbdb_bridge wbdb_bridge_i (.clk, .reset, .clkEn, .transmitClock,
    .dmaDataStrobe, .ctrlReadDir, .byteMode, .addrLatchStrobe, .ctrlReady,
    .busGrantAck, .cpuRd, .cpuWr, .portCycleRequest, .opcodeFetchCycle,
    .intReq, .nmiReq, .holdReq, .cpuAddr, .ctrlAddrHigh,
    .sharedAddressDataIn, .sharedAddressDataOut, .sharedAddressDataOe,
    .cpuDataIn, .cpuDataOut, .cpuDataOe, .memDataIn, .memDataOut,
    .memDataOe, .holdGrant, .stateBitZero, .upperStateBits,
    .memoryRequestStrobe, .memRead, .memStore, .lowAddressSelect,
    .dmaReady, .ioDataStrobe, .ioCtrlRead, .cpuWait, .dmaAddr,
    .dmaAddrHigh, .bankAddr, .bankAddrOe, .intSync, .nmiSync,
    .busRequestSync);
  wbdb_mem_model wbdb_mem_model_i (.clk, .memRead, .lowAddressSelect,
    .loByte(memLo), .hiByte(memHi), .memData(memDataIn));

  always #5 clk = ~clk;

  task automatic finishTest();
    if (numErrors == 0 && samplesChecked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : finishTest

  // Hang guard sized well above the full sequence
  always @(posedge clk) begin
    cycles++;
    if (cycles == 8000) begin
      numErrors++;
      finishTest();
    end
  end

  task automatic chk(input string what, input logic [15:0] seen,
                     input logic [15:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      numErrors++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic tpulse();
    transmitClock = 1'b1;
    tick(5);
    transmitClock = 1'b0;
    tick(5);
  endtask : tpulse

  task automatic io(input logic [8:0] a, input logic rd, input logic wr,
                    input logic [7:0] d);
    cpuAddr = a;
    cpuDataIn = d;
    portCycleRequest = 1'b1;
    cpuRd = rd;
    cpuWr = wr;
    tick(8);
  endtask : io

  task automatic ioEnd();
    {portCycleRequest, cpuRd, cpuWr} = 3'h0;
    tick(8);
  endtask : ioEnd

  // Expected {request, read, store, low select, ready} for a state
  function automatic logic [4:0] strobes(input logic [3:0] s,
    input logic rd, input logic bm, input logic a0);
    logic pre, st, low, rdy;
    pre = s[1] & s[2] & !s[3];
    if (bm) begin
      st = s[1] | s[2] | s[3];
      low = a0;
      rdy = 1'b1;
    end else begin
      st = (s[1] & !s[2] & !s[3]) | (!s[0] & !s[1] & s[2])
         | (!s[1] & s[2] & s[3]);
      low = s[2] | s[3];
      rdy = (!s[0] & !s[1] & s[2]) | (!s[1] & s[2] & !s[3]) | s[3];
    end
    return {!pre, rd & !pre, !rd & st, low, rdy};
  endfunction : strobes

  task automatic frame(input logic rd, input logic bm);
    int k;
    logic [3:0] st, hiA;
    logic [4:0] e;
    logic [15:0] adr, wd;
    adr = 16'($urandom);
    wd = 16'($urandom);
    hiA = 4'($urandom);
    memLo = 8'($urandom);
    memHi = 8'($urandom);
    byteMode = bm;
    ctrlReadDir = rd;
    sharedAddressDataIn = adr;
    ctrlAddrHigh = hiA;
    addrLatchStrobe = 1'b1;
    tick(8);
    addrLatchStrobe = 1'b0;
    // Latch strobe is seen through the synchroniser: hold the address
    tick(6);
    sharedAddressDataIn = wd;
    chk("dmaAddr", {1'b0, dmaAddr}, {1'b0, adr[15:1]});
    chk("dmaAddrHigh", dmaAddrHigh, hiA);
    dmaDataStrobe = 1'b1;
    tick(10);
    for (k = 0; k <= 16; k++) begin
      st = grayTab[k % 16];
      e = strobes(st, rd, bm, adr[0]);
      chk("sequence", {stateBitZero, upperStateBits}, {k[0], st});
      chk("strobes", {memoryRequestStrobe, memRead, memStore,
          lowAddressSelect, dmaReady}, e);
      if (!bm && rd && st == ST_SECOND) begin
        chk("readWord", sharedAddressDataOut, {memHi, memLo});
        chk("readLanes", sharedAddressDataOe, 2'h3);
      end
      if (!bm && !rd && e[2]) begin
        chk("writeByte", {memDataOe, memDataOut},
            {1'b1, e[1] ? wd[15:8] : wd[7:0]});
      end
      if (bm && rd && k == 1) begin
        chk("byteLane", sharedAddressDataOe, adr[0] ? 2'h2 : 2'h1);
      end
      chk("bankFloat", bankAddrOe, 1'b0);
      if (k < 16) begin
        tpulse();
      end
    end
    dmaDataStrobe = 1'b0;
    tick(8);
    chk("frameEnd", {memoryRequestStrobe, memRead, memStore, stateBitZero,
        upperStateBits}, 8'h00);
    chk("readyEnd", dmaReady, 1'b0);
  endtask : frame

  initial begin
    clk = 1'b0;
    reset = 1'b1;
    clkEn = 1'b1;
    {transmitClock, dmaDataStrobe, ctrlReadDir, byteMode} = 4'h0;
    {addrLatchStrobe, ctrlReady, busGrantAck, cpuRd, cpuWr} = 5'h00;
    {portCycleRequest, opcodeFetchCycle, intReq, nmiReq, holdReq} = 5'h00;
    {cpuAddr, ctrlAddrHigh, sharedAddressDataIn} = '0;
    {cpuDataIn, memLo, memHi} = '0;
    w = 16'($urandom(32'h3482BEEA));
    tick(6);
    chk("resetOe", {bankAddrOe, holdGrant, bankAddr}, 10'h200);
    chk("resetStrobes", {memoryRequestStrobe, dmaReady, ioDataStrobe},
        3'h0);
    reset = 1'b0;
    tick(2);
    repeat (4) begin
      b = 8'($urandom);
      {intReq, nmiReq, holdReq} = b[2:0];
      tick(8);
      chk("sync", {intSync, nmiSync, busRequestSync}, b[2:0]);
    end
    lo = 8'($urandom);
    hi = 8'($urandom);
    io(PORT_STAGE, 1'b0, 1'b1, lo);
    ioEnd();
    io(PORT_HI, 1'b0, 1'b1, hi);
    chk("ioWrite", {ioDataStrobe, ioCtrlRead}, 2'h2);
    chk("ioWord", sharedAddressDataOut, {hi, lo});
    chk("waitBusy", cpuWait, 1'b1);
    ctrlReady = 1'b1;
    tick(8);
    chk("waitFree", cpuWait, 1'b0);
    ioEnd();
    chk("ioIdle", ioDataStrobe, 1'b0);
    w = 16'($urandom);
    sharedAddressDataIn = w;
    io(PORT_HI, 1'b1, 1'b0, 8'h00);
    chk("ioRead", {ioDataStrobe, ioCtrlRead}, 2'h3);
    chk("readHigh", {cpuDataOe, cpuDataOut}, {1'b1, w[15:8]});
    ioEnd();
    sharedAddressDataIn = ~w;
    io(PORT_STAGE, 1'b1, 1'b0, 8'h00);
    chk("readLow", cpuDataOut, w[7:0]);
    ioEnd();
    opcodeFetchCycle = 1'b1;
    io(PORT_HI, 1'b0, 1'b1, 8'h00);
    chk("fetchBlock", {ioDataStrobe, sharedAddressDataOe}, 3'h0);
    ioEnd();
    opcodeFetchCycle = 1'b0;
    b = 8'($urandom);
    io(PORT_BANK, 1'b0, 1'b1, b);
    ioEnd();
    chk("bank", {bankAddrOe, bankAddr}, {1'b1, b});
    busGrantAck = 1'b1;
    tick(8);
    chk("holdGrant", holdGrant, 1'b1);
    frame(1'b1, 1'b0);
    frame(1'b0, 1'b0);
    frame(1'b1, 1'b1);
    frame(1'b0, 1'b1);
    // Grant withdrawn mid-run must park the sequencer
    dmaDataStrobe = 1'b1;
    tick(10);
    repeat (3) tpulse();
    busGrantAck = 1'b0;
    tick(8);
    chk("grantLost", {holdGrant, memoryRequestStrobe, stateBitZero,
        upperStateBits}, 7'h00);
    // Mid-run reset must clear the bank register written earlier
    reset = 1'b1;
    tick(2);
    chk("bankClear", {bankAddrOe, bankAddr}, 9'h100);
    reset = 1'b0;
    tick(2);
    finishTest();
  end
endmodule : wbdb_bridge_bench
